/* logic/sds_sequencer.v */
// Step and direction sequencer with microstep table and adaptive current.
// Assumes step and dir come from an external pulse source and all
// settings are static ports driven from the ref_clk domain.
`timescale 1ns/1ps
`include "sds_consts.vh"

module sds_sequencer (
  input wire ref_clk,
  input wire rst_n,
  input wire step_in,
  input wire dir_in,
  input wire double_edge,
  input wire [3:0] resolution,
  input wire [4:0] run_current,
  input wire [4:0] hold_current,
  input wire hold_select,
  input wire [`SDS_TSTEP_W-1:0] lower_velocity_threshold,
  input wire [`SDS_TSTEP_W-1:0] upper_velocity_threshold,
  input wire [`SDS_LOAD_W-1:0] load_measure_value,
  input wire load_measure_valid,
  input wire load_filter,
  input wire [3:0] lower_load_threshold,
  input wire [3:0] upper_load_window,
  input wire [1:0] current_increment_step,
  input wire [1:0] current_decrement_rate,
  input wire min_current_select,
  output reg [`SDS_CNT_W-1:0] microstep_count_q,
  output reg signed [`SDS_AMP_W-1:0] coil_a_q,
  output reg signed [`SDS_AMP_W-1:0] coil_b_q,
  output reg [`SDS_CS_W-1:0] current_scale_q,
  output reg adaptive_active_q,
  output reg [`SDS_TSTEP_W-1:0] step_period_q
);

  // Nearest position of the coarser grid: multiples of the width offset by
  // half a width, so steps stay symmetric in both directions.
  function [`SDS_CNT_W-1:0] snap;
    input [`SDS_CNT_W-1:0] pos;
    input [`SDS_CNT_W-1:0] width;
    begin
      snap = (pos & ~(width - `SDS_CNT_ONE)) | (width >> 1);
    end
  endfunction

  function [5:0] dn_need;
    input [1:0] code;
    begin
      case (code)
        2'h0: dn_need = `SDS_DN_N0;
        2'h1: dn_need = `SDS_DN_N1;
        2'h2: dn_need = `SDS_DN_N2;
        default: dn_need = `SDS_DN_N3;
      endcase
    end
  endfunction

  // Input synchronisers; the first stage feeds only the second.
  reg step_s1_q;
  reg step_s2_q;
  reg step_s3_q;
  reg dir_s1_q;
  reg dir_s2_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_s1_q <= 1'b0;
      step_s2_q <= 1'b0;
      step_s3_q <= 1'b0;
      dir_s1_q <= 1'b0;
      dir_s2_q <= 1'b0;
    end else begin
      step_s1_q <= step_in;
      step_s2_q <= step_s1_q;
      step_s3_q <= step_s2_q;
      dir_s1_q <= dir_in;
      dir_s2_q <= dir_s1_q;
    end
  end

  // A rate above the documented limit merges edges in the synchroniser.
  wire step_evt = double_edge ? (step_s2_q ^ step_s3_q) :
                  (step_s2_q & ~step_s3_q);

  // Microstep counter.
  reg [3:0] res_prev_q;
  wire [3:0] res_eff = (resolution > `SDS_RES_FULL) ? `SDS_RES_FULL :
                       resolution;
  wire [`SDS_CNT_W-1:0] width = `SDS_CNT_ONE << res_eff;
  wire coarser = res_eff > res_prev_q;
  reg [`SDS_CNT_W-1:0] base;
  reg [`SDS_CNT_W-1:0] cnt_d;

  always @* begin
    if (coarser) begin
      base = snap(microstep_count_q, width);
    end else begin
      base = microstep_count_q;
    end
    if (step_evt && dir_s2_q) begin
      cnt_d = base - width;
    end else if (step_evt) begin
      cnt_d = base + width;
    end else begin
      cnt_d = base;
    end
  end

  wire signed [`SDS_AMP_W-1:0] sine_a;
  wire signed [`SDS_AMP_W-1:0] sine_b;

  sds_sine_lut u_lut_a (
    .phase(microstep_count_q),
    .amplitude(sine_a)
  );

  sds_sine_lut u_lut_b (
    .phase(microstep_count_q + `SDS_COS_SHIFT),
    .amplitude(sine_b)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_prev_q <= `SDS_RES_FINE;
      microstep_count_q <= `SDS_CNT_RESET;
      coil_a_q <= `SDS_AMP_ZERO;
      coil_b_q <= `SDS_AMP_ZERO;
    end else begin
      res_prev_q <= res_eff;
      microstep_count_q <= cnt_d;
      coil_a_q <= sine_a;
      coil_b_q <= sine_b;
    end
  end

  // Step period in clocks, saturating, stands in for the velocity.
  reg [`SDS_TSTEP_W-1:0] period_cnt_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_q <= `SDS_TSTEP_ONE;
      step_period_q <= `SDS_TSTEP_MAX;
    end else if (step_evt) begin
      step_period_q <= period_cnt_q;
      period_cnt_q <= `SDS_TSTEP_ONE;
    end else if (period_cnt_q != `SDS_TSTEP_MAX) begin
      period_cnt_q <= period_cnt_q + `SDS_TSTEP_ONE;
    end
  end

  // Slow motion means a long period: lower velocity limit is a ceiling on
  // the period, upper velocity limit a floor.
  wire vel_ok = (step_period_q <= lower_velocity_threshold) &&
                (step_period_q >= upper_velocity_threshold);
  wire adapt_on = (lower_load_threshold != 4'h0) && vel_ok &&
                  !hold_select;

  // Load measurement filter: averages four readings into one.
  reg [1:0] filt_cnt_q;
  reg [`SDS_LOAD_W+1:0] filt_acc_q;
  wire [`SDS_LOAD_W+1:0] filt_sum = filt_acc_q +
                                    {2'h0, load_measure_value};
  wire filt_done = load_measure_valid && filt_cnt_q == `SDS_FILT_LAST;
  wire sample_evt = load_filter ? filt_done : load_measure_valid;
  wire [`SDS_LOAD_W-1:0] sample = load_filter ?
       filt_sum[`SDS_LOAD_W+1:2] : load_measure_value;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt_q <= `SDS_FILT_ZERO;
      filt_acc_q <= {(`SDS_LOAD_W+2){1'b0}};
    end else if (!load_filter) begin
      filt_cnt_q <= `SDS_FILT_ZERO;
      filt_acc_q <= {(`SDS_LOAD_W+2){1'b0}};
    end else if (filt_done) begin
      filt_cnt_q <= `SDS_FILT_ZERO;
      filt_acc_q <= {(`SDS_LOAD_W+2){1'b0}};
    end else if (load_measure_valid) begin
      filt_cnt_q <= filt_cnt_q + 2'h1;
      filt_acc_q <= filt_sum;
    end
  end

  // Thresholds and bounds.
  wire [`SDS_LOAD_W-1:0] lo_thr = {1'b0, lower_load_threshold,
                                   `SDS_THR_SCALE};
  wire [4:0] hi_sum = {1'b0, lower_load_threshold} +
                      {1'b0, upper_load_window} + 5'h01;
  wire [`SDS_LOAD_W-1:0] hi_thr = {hi_sum, `SDS_THR_SCALE};
  wire [5:0] cs_max = {1'b0, run_current};
  wire [5:0] cs_min = min_current_select ? {3'h0, run_current[4:2]} :
                      {2'h0, run_current[4:1]};
  wire [5:0] cs_now = {1'b0, current_scale_q};
  wire [5:0] cs_up = cs_now + (`SDS_CS_ONE << current_increment_step);
  wire [5:0] cs_dn = cs_now - `SDS_CS_ONE;

  reg [5:0] dn_cnt_q;
  reg [5:0] dn_cnt_d;
  reg [5:0] cs_d;

  always @* begin
    cs_d = cs_now;
    dn_cnt_d = dn_cnt_q;
    if (!adapt_on) begin
      cs_d = hold_select ? {1'b0, hold_current} : cs_max;
      dn_cnt_d = `SDS_DN_ZERO;
    end else if (sample_evt && sample < lo_thr) begin
      cs_d = (cs_up > cs_max) ? cs_max : cs_up;
      dn_cnt_d = `SDS_DN_ZERO;
    end else if (sample_evt && sample >= hi_thr) begin
      if (dn_cnt_q + `SDS_CS_ONE >= dn_need(current_decrement_rate)) begin
        cs_d = (cs_dn < cs_min || cs_now == 6'h00) ? cs_min : cs_dn;
        dn_cnt_d = `SDS_DN_ZERO;
      end else begin
        dn_cnt_d = dn_cnt_q + `SDS_CS_ONE;
      end
    end else if (sample_evt) begin
      dn_cnt_d = `SDS_DN_ZERO;
    end else if (cs_now > cs_max) begin
      cs_d = cs_max;
    end else if (cs_now < cs_min) begin
      cs_d = cs_min;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_scale_q <= {`SDS_CS_W{1'b0}};
      dn_cnt_q <= `SDS_DN_ZERO;
      adaptive_active_q <= 1'b0;
    end else begin
      current_scale_q <= cs_d[`SDS_CS_W-1:0];
      dn_cnt_q <= dn_cnt_d;
      adaptive_active_q <= adapt_on;
    end
  end

endmodule

/* logic/sds_consts.vh */
// Shared constants of the step and direction microstep sequencer.
// Included by the sequencer and its sine lookup; holds definitions only.
`ifndef SDS_CONSTS_VH
`define SDS_CONSTS_VH

// Microstep counter and table geometry.
`define SDS_CNT_W 10
`define SDS_CNT_ONE 10'h001
`define SDS_CNT_RESET 10'h000
`define SDS_QUARTER 9'h100
`define SDS_COS_SHIFT 10'h100
// Resolution code: 0 is finest (width 1), 8 is full step (width 256).
`define SDS_RES_FINE 4'h0
`define SDS_RES_FULL 4'h8
// Sine output.
`define SDS_AMP_W 9
`define SDS_AMP_ZERO 9'h000
// Step period measurement.
`define SDS_TSTEP_W 20
`define SDS_TSTEP_MAX 20'hf_ffff
`define SDS_TSTEP_ONE 20'h0_0001
// Load measurement and adaptive current regulation.
`define SDS_LOAD_W 10
`define SDS_THR_SCALE 5'h00
`define SDS_FILT_LAST 2'h3
`define SDS_FILT_ZERO 2'h0
`define SDS_CS_W 5
`define SDS_CS_ONE 6'h01
`define SDS_DN_N0 6'h20
`define SDS_DN_N1 6'h08
`define SDS_DN_N2 6'h02
`define SDS_DN_N3 6'h01
`define SDS_DN_ZERO 6'h00

`endif

/* logic/sds_sine_lut.v */
// Signed sine lookup over 1024 phase positions for one coil.
// Assumes a phase that the sequencer holds stable; purely combinational.
`timescale 1ns/1ps
`include "sds_consts.vh"

module sds_sine_lut (
  input wire [`SDS_CNT_W-1:0] phase,
  output reg signed [`SDS_AMP_W-1:0] amplitude
);

  // A coarse quarter wave with linear fill keeps the area small, at the
  // cost of up to one count of error between the stored points.
  function [7:0] coarse;
    input [5:0] idx;
    begin
      case (idx)
        6'h00: coarse = 8'h00;
        6'h01: coarse = 8'h0c;
        6'h02: coarse = 8'h18;
        6'h03: coarse = 8'h24;
        6'h04: coarse = 8'h30;
        6'h05: coarse = 8'h3c;
        6'h06: coarse = 8'h48;
        6'h07: coarse = 8'h54;
        6'h08: coarse = 8'h5f;
        6'h09: coarse = 8'h6a;
        6'h0a: coarse = 8'h75;
        6'h0b: coarse = 8'h7f;
        6'h0c: coarse = 8'h8a;
        6'h0d: coarse = 8'h94;
        6'h0e: coarse = 8'h9d;
        6'h0f: coarse = 8'ha7;
        6'h10: coarse = 8'haf;
        6'h11: coarse = 8'hb8;
        6'h12: coarse = 8'hc0;
        6'h13: coarse = 8'hc7;
        6'h14: coarse = 8'hce;
        6'h15: coarse = 8'hd5;
        6'h16: coarse = 8'hdb;
        6'h17: coarse = 8'he0;
        6'h18: coarse = 8'he5;
        6'h19: coarse = 8'hea;
        6'h1a: coarse = 8'hed;
        6'h1b: coarse = 8'hf1;
        6'h1c: coarse = 8'hf3;
        6'h1d: coarse = 8'hf5;
        6'h1e: coarse = 8'hf7;
        default: coarse = 8'hf8;
      endcase
    end
  endfunction

  function [7:0] quarter_amp;
    input [8:0] q;
    reg [7:0] lo;
    reg [7:0] hi;
    reg [10:0] step;
    begin
      lo = coarse(q[8:3]);
      hi = coarse(q[8:3] + 6'h01);
      step = ({3'h0, hi} - {3'h0, lo}) * {8'h00, q[2:0]};
      quarter_amp = lo + step[10:3];
    end
  endfunction

  reg [8:0] q;
  reg [7:0] mag;

  always @* begin
    if (phase[8]) begin
      q = `SDS_QUARTER - {1'b0, phase[7:0]};
    end else begin
      q = {1'b0, phase[7:0]};
    end
    mag = quarter_amp(q);
    if (phase[9]) begin
      amplitude = `SDS_AMP_ZERO - {1'b0, mag};
    end else begin
      amplitude = {1'b0, mag};
    end
  end

endmodule

/* bench/sds_sequencer_assertions.sv */
// Concurrent checks on the ports of the microstep sequencer.
// Assumes a single ref_clk domain with rst_n as its async reset.
`timescale 1ns/1ps
module sds_sequencer_assertions (
  input wire ref_clk,
  input wire rst_n,
  input wire step_in,
  input wire dir_in,
  input wire double_edge,
  input wire [3:0] resolution,
  input wire [4:0] run_current,
  input wire [9:0] load_measure_value,
  input wire load_measure_valid,
  input wire load_filter,
  input wire [3:0] lower_load_threshold,
  input wire [3:0] upper_load_window,
  input wire [1:0] current_increment_step,
  input wire [1:0] current_decrement_rate,
  input wire min_current_select,
  input wire [9:0] microstep_count_q,
  input wire signed [8:0] coil_a_q,
  input wire signed [8:0] coil_b_q,
  input wire [4:0] current_scale_q,
  input wire adaptive_active_q
);
  wire [9:0] w = (resolution > 4'h8) ? 10'h100 : (10'h001 << resolution);
  wire [5:0] up_sum = current_scale_q + (6'h01 << current_increment_step);
  wire [4:0] up_exp = (up_sum > run_current) ? run_current : up_sum[4:0];
  wire [4:0] floor_v = min_current_select ? run_current >> 2 : run_current >> 1;
  wire [4:0] hi_sum = lower_load_threshold + upper_load_window + 5'h01;
  wire [9:0] lo_thr = {1'b0, lower_load_threshold, 5'h00};
  wire [9:0] hi_thr = {hi_sum, 5'h00};
  wire ev = load_measure_valid && !load_filter && adaptive_active_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The step reaches the counter on the third edge, so it is seen one later.
  chk_step_adds: assert property (
    ($rose(step_in) || $fell(step_in) && double_edge) && !dir_in &&
    $stable(resolution) |-> ##3
    microstep_count_q == $past(microstep_count_q) + w)
    else $error("count did not advance by the width");
  chk_step_subtracts: assert property (
    ($rose(step_in) || $fell(step_in) && double_edge) && dir_in &&
    $stable(resolution) |-> ##3
    microstep_count_q == $past(microstep_count_q) - w)
    else $error("count did not retreat by the width");
  chk_fall_ignored: assert property (
    $fell(step_in) && !double_edge && $stable(resolution) |-> ##3
    $stable(microstep_count_q)) else $error("falling step edge counted");
  chk_full_grid: assert property (
    resolution == 4'h8 && $past(resolution) == 4'h8 && $past(rst_n) |->
    microstep_count_q[7:0] == 8'h80) else $error("full step off grid");
  chk_coil_balance: assert property (
    resolution == 4'h8 && $past(resolution) == 4'h8 && $past(rst_n) &&
    $stable(microstep_count_q) |-> coil_a_q == coil_b_q ||
    coil_a_q == -coil_b_q) else $error("coils unequal at full step");
  chk_scale_raise: assert property (
    ev && load_measure_value < lo_thr |=>
    current_scale_q == $past(up_exp)) else $error("scale not raised");
  chk_scale_lower: assert property (
    ev && load_measure_value >= hi_thr && current_decrement_rate == 2'h3 &&
    current_scale_q > floor_v |=>
    current_scale_q == $past(current_scale_q) - 5'h01)
    else $error("scale not lowered");
  chk_zero_disables: assert property (
    lower_load_threshold == 4'h0 |=> !adaptive_active_q)
    else $error("regulation active with zero threshold");
endmodule

bind sds_sequencer sds_sequencer_assertions u_sds_sequencer_assertions (
  .ref_clk(ref_clk), .rst_n(rst_n), .step_in(step_in), .dir_in(dir_in),
  .double_edge(double_edge), .resolution(resolution),
  .run_current(run_current), .load_measure_value(load_measure_value),
  .load_measure_valid(load_measure_valid), .load_filter(load_filter),
  .lower_load_threshold(lower_load_threshold),
  .upper_load_window(upper_load_window),
  .current_increment_step(current_increment_step),
  .current_decrement_rate(current_decrement_rate),
  .min_current_select(min_current_select),
  .microstep_count_q(microstep_count_q), .coil_a_q(coil_a_q),
  .coil_b_q(coil_b_q), .current_scale_q(current_scale_q),
  .adaptive_active_q(adaptive_active_q));

/* bench/sds_step_source.sv */
// Model of the external motion controller driving step and dir.
// Assumes the bench calls toggle(); it drives at falling edges only.
`timescale 1ns/1ps
module sds_step_source (
  input wire ref_clk,
  output reg step_in,
  output reg dir_in
);
  initial begin
    step_in = 1'b0;
    dir_in = 1'b0;
  end
  // Dir settles two clocks early, and edges stay seven clocks apart.
  task toggle(input logic dir);
    begin
      @(negedge ref_clk) dir_in = dir;
      repeat (2) @(negedge ref_clk);
      step_in = ~step_in;
      repeat (4) @(negedge ref_clk);
    end
  endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the microstep sequencer.
// Assumes the step source model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb_top;
  reg ref_clk = 1'b0, rst_n = 1'b0, double_edge = 1'b0, hold_select = 1'b0;
  reg load_measure_valid = 1'b0, load_filter = 1'b0, min_current_select = 1'b0;
  reg [3:0] resolution = 4'h0, lower_load_threshold = 4'h1;
  reg [3:0] upper_load_window = 4'h1;
  reg [4:0] run_current = 5'h10, hold_current = 5'h04;
  reg [19:0] lower_velocity_threshold = 20'hf_ffff;
  reg [19:0] upper_velocity_threshold = 20'h0_0000;
  reg [9:0] load_measure_value = 10'h000, exp_cnt = 10'h000;
  reg [1:0] current_increment_step = 2'h0, current_decrement_rate = 2'h3;
  wire step_in, dir_in, adaptive_active_q;
  wire [9:0] microstep_count_q;
  wire signed [8:0] coil_a_q, coil_b_q;
  wire [4:0] current_scale_q;
  wire [19:0] step_period_q;
  int err_count = 0, n_compared = 0, i;
  reg [4:0] e;
  initial forever #2.5 ref_clk = ~ref_clk;
  sds_step_source u_sds_step_source (.ref_clk(ref_clk), .step_in(step_in),
    .dir_in(dir_in));
  sds_sequencer u_sds_sequencer (.ref_clk(ref_clk), .rst_n(rst_n),
    .step_in(step_in), .dir_in(dir_in), .double_edge(double_edge),
    .resolution(resolution), .run_current(run_current),
    .hold_current(hold_current), .hold_select(hold_select),
    .lower_velocity_threshold(lower_velocity_threshold),
    .upper_velocity_threshold(upper_velocity_threshold),
    .load_measure_value(load_measure_value),
    .load_measure_valid(load_measure_valid), .load_filter(load_filter),
    .lower_load_threshold(lower_load_threshold),
    .upper_load_window(upper_load_window),
    .current_increment_step(current_increment_step),
    .current_decrement_rate(current_decrement_rate),
    .min_current_select(min_current_select),
    .microstep_count_q(microstep_count_q), .coil_a_q(coil_a_q),
    .coil_b_q(coil_b_q), .current_scale_q(current_scale_q),
    .adaptive_active_q(adaptive_active_q), .step_period_q(step_period_q));
  task check(input logic [19:0] seen, input logic [19:0] want,
    input string msg);
    begin
      n_compared++;
      if (seen !== want) begin
        err_count++;
        $display("mismatch at %0t: %s", $time, msg);
      end
    end
  endtask
  task pulse(input logic dir, input logic [9:0] w);
    begin
      u_sds_step_source.toggle(dir);
      u_sds_step_source.toggle(dir);
      exp_cnt = dir ? exp_cnt - w : exp_cnt + w;
      check(microstep_count_q, exp_cnt, "count");
    end
  endtask
  task load(input logic [9:0] v, input logic [4:0] want);
    begin
      @(negedge ref_clk) load_measure_value = v;
      load_measure_valid = 1'b1;
      @(negedge ref_clk) load_measure_valid = 1'b0;
      check(current_scale_q, want, "scale");
    end
  endtask
  task t_steps;
    begin
      pulse(1'b1, 10'h001);
      for (i = 0; i < 3; i++) pulse(1'b0, 10'h001);
      @(negedge ref_clk) double_edge = 1'b1;
      u_sds_step_source.toggle(1'b0);
      u_sds_step_source.toggle(1'b0);
      exp_cnt = exp_cnt + 10'h002;
      check(microstep_count_q, exp_cnt, "double edge");
      @(negedge ref_clk) double_edge = 1'b0;
      pulse(1'b0, 10'h001);
    end
  endtask
  task t_resolution;
    begin
      for (i = 1; i <= 8; i++) begin
        @(negedge ref_clk) resolution = i[3:0];
        repeat (2) @(negedge ref_clk);
        exp_cnt = (exp_cnt & ~((10'h001 << i) - 10'h001)) |
          (10'h001 << (i - 1));
        check(microstep_count_q, exp_cnt, "snap");
      end
      for (i = 0; i < 5; i++) begin
        pulse(1'b0, 10'h100);
        check(coil_a_q < 0 ? -coil_a_q : coil_a_q, 20'h0_00af, "coil");
        check(coil_b_q < 0 ? -coil_b_q : coil_b_q, 20'h0_00af, "coil");
      end
    end
  endtask
  task t_regulate;
    begin
      // The scale leaves reset at the floor, so a brief disable loads run.
      @(negedge ref_clk) lower_load_threshold = 4'h0;
      @(negedge ref_clk) lower_load_threshold = 4'h1;
      check(current_scale_q, run_current, "scale at run");
      for (i = 15; i >= 7; i--) load(10'h060, i < 8 ? 5'h08 : i[4:0]);
      load(10'h05f, 5'h08);
      e = 5'h08;
      for (i = 0; i < 4; i++) begin
        current_increment_step = i[1:0];
        e = (e + (5'h01 << i) > 5'h10) ? 5'h10 : e + (5'h01 << i);
        load(10'h01f, e);
      end
      load(10'h020, 5'h10);
      load_filter = 1'b1;
      for (i = 0; i < 4; i++) load(10'h3ff, i == 3 ? 5'h0f : 5'h10);
      load_filter = 1'b0;
      min_current_select = 1'b1;
      for (i = 14; i >= 3; i--) load(10'h3ff, i < 4 ? 5'h04 : i[4:0]);
      @(negedge ref_clk) lower_load_threshold = 4'h0;
      repeat (2) @(negedge ref_clk);
      check(adaptive_active_q, 20'h0_0000, "regulation off");
      check(current_scale_q, run_current, "run current");
      hold_select = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(current_scale_q, hold_current, "hold current");
      hold_select = 1'b0;
      lower_load_threshold = 4'h1;
      upper_velocity_threshold = 20'hf_ffff;
      repeat (2) @(negedge ref_clk);
      check(adaptive_active_q, 20'h0_0000, "above upper speed");
      check(current_scale_q, run_current, "run above speed");
      upper_velocity_threshold = 20'h0_0000;
      lower_velocity_threshold = 20'h0_0001;
      repeat (2) @(negedge ref_clk);
      check(adaptive_active_q, 20'h0_0000, "below lower speed");
      check(current_scale_q, run_current, "run below speed");
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    t_steps;
    t_resolution;
    // Rising step edges of back-to-back pulses lie fourteen clocks apart.
    check(step_period_q, 20'h0_000e, "step period");
    t_regulate;
    stop_test;
  end
  // The tests need about 270 clocks; this leaves a wide margin.
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule
